// *** core/rcd_core.sv ***
// Purpose: 8-bit core: fetch, register file, alu, stack, interrupts
// Assumes: program and data memories answer one cycle after a read
// Notes: irq_pend lines are already gated by per-source enables

module rcd_core #(
   parameter int IRQ_N = 8,
   parameter logic [15:0] BOOT_START = 16'h1C00
) (
   input logic clk_sys,
   input logic rst,
   output logic [15:0] prog_addr,
   input logic [15:0] prog_data,
   output logic [15:0] dmem_addr,
   output logic [7:0] dmem_wdata,
   output logic dmem_we,
   output logic dmem_re,
   input logic [7:0] dmem_rdata,
   output logic [5:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_we,
   output logic io_re,
   input logic [7:0] io_rdata,
   input logic [IRQ_N-1:0] irq_pend,
   output logic irq_ack,
   output logic [$clog2(IRQ_N)-1:0] irq_ack_id,
   input logic app_lock,
   input logic boot_lock,
   output logic flash_wr_en,
   output logic [15:0] flash_wr_addr,
   output logic [15:0] flash_wr_data
);
   import rcd_pkg::*;

   typedef struct packed {
      logic [NREG-1:0][7:0] rf;
      logic [15:0] pc, sp, tmp, jt, ir;
      logic [7:0] fl;
      logic fv, irq_exit_instr;
      logic [1:0] ld_src;
      logic [4:0] ld_dst;
      rcd_state_t st;
      logic fw_en;
      logic [15:0] fw_addr, fw_data;
   } rcd_regs_t;

   rcd_regs_t s, n;
   logic [15:0] ins, xa, zp, pv, aa, alu_o;
   logic [16:0] prod;
   logic [7:0] ad, iv;
   logic [5:0] ioa;
   logic [4:0] di, ptr, adst;
   logic exec, ard, awr;

   function automatic logic [15:0] alu_f(input logic [3:0] op,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
      logic [7:0] x, y, r, o;
      logic [8:0] w;
      logic [4:0] hw;
      logic sub, ci;
      o = f;
      sub = (op == A_SUB) || (op == A_SBC) || (op == A_NEG)
         || (op == A_DEC);
      ci = ((op == A_ADC) || (op == A_SBC)) ? f[F_C] : 1'b0;
      x = (op == A_NEG) ? 8'h00 : a;
      y = (op == A_NEG) ? a : ((op == A_INC || op == A_DEC) ? 8'h01 : b);
      w = sub ? {1'b0, x} - {1'b0, y} - {8'h00, ci}
         : {1'b0, x} + {1'b0, y} + {8'h00, ci};
      hw = sub ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci}
         : {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      r = w[7:0];
      case (op)
         A_ADD, A_ADC, A_SUB, A_SBC, A_NEG: begin
            o[F_C] = w[8];
            o[F_H] = hw[4];
            o[F_V] = sub ? (x[7] != y[7]) && (r[7] != x[7])
               : (x[7] == y[7]) && (r[7] != x[7]);
         end
         A_INC, A_DEC: o[F_V] = sub ? (x == 8'h80) : (x == 8'h7F);
         A_AND, A_OR, A_EOR, A_COM: begin
            r = (op == A_AND) ? a & b : (op == A_OR) ? a | b
               : (op == A_EOR) ? a ^ b : ~a;
            o[F_V] = 1'b0;
            if (op == A_COM) o[F_C] = 1'b1;
         end
         A_SHR, A_ROTR, A_SAR: begin
            r = {(op == A_SHR) ? 1'b0 : (op == A_ROTR) ? f[F_C] : a[7],
               a[7:1]};
            o[F_C] = a[0];
            o[F_V] = r[7] ^ a[0];
         end
         A_NIB: r = {a[3:0], a[7:4]};
         default: r = b;
      endcase
      if (op != A_MOV && op != A_NIB) begin
         o[F_N] = r[7];
         o[F_Z] = (r == 8'h00);
         o[F_S] = r[7] ^ o[F_V];
      end
      return {o, r};
   endfunction

   function automatic logic [16:0] mul_f(input logic [1:0] m,
      input logic [7:0] a, input logic [7:0] b);
      logic signed [17:0] p;
      p = $signed({a[7] & (|m), a}) * $signed({b[7] & m[0], b});
      if (m == M_FRAC) return {p[15], p[14:0], 1'b0};
      return {p[15], p[15:0]};
   endfunction

   function automatic logic [$clog2(IRQ_N)-1:0] low_f(
      input logic [IRQ_N-1:0] p);
      logic [$clog2(IRQ_N)-1:0] k;
      k = '0;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (p[i]) k = ($clog2(IRQ_N))'(i);
      end
      return k;
   endfunction

   always_comb begin
      n = s;
      n.fw_en = 1'b0;
      ins = prog_data;
      xa = s.pc - 16'h0001;
      di = ins[4:0];
      ptr = 5'(R_X + {2'h0, ins[12:11], 1'b0});
      pv = {s.rf[ptr + 5'h01], s.rf[ptr]};
      zp = {s.rf[R_Z + 5'h01], s.rf[R_Z]};
      aa = '0;
      ad = '0;
      iv = '0;
      ioa = '0;
      adst = di;
      ard = 1'b0;
      awr = 1'b0;
      exec = 1'b0;
      alu_o = '0;
      prod = '0;
      dmem_addr = '0;
      dmem_wdata = '0;
      dmem_we = 1'b0;
      dmem_re = 1'b0;
      io_addr = '0;
      io_wdata = '0;
      io_we = 1'b0;
      io_re = 1'b0;
      irq_ack = 1'b0;
      irq_ack_id = '0;
      case (s.st)
         S_RUN: begin
            n.pc = s.pc + 16'h0001;
            n.fv = 1'b1;
            if (!s.fv) begin
               n.fv = 1'b1;
            end else if (s.fl[F_I] && (|irq_pend)) begin
               irq_ack = 1'b1;
               irq_ack_id = low_f(irq_pend);
               n.fl[F_I] = 1'b0;
               n.tmp = xa;
               n.jt = 16'(VEC_STEP * (16'(irq_ack_id) + 16'h0001));
               n.st = S_PUSH1;
            end else begin
               exec = 1'b1;
               case (ins[15:13])
                  C_RR: begin
                     alu_o = alu_f({1'b0, ins[12:10]}, s.rf[ins[9:5]],
                        s.rf[di], s.fl);
                     n.rf[ins[9:5]] = alu_o[7:0];
                     n.fl = alu_o[15:8];
                  end
                  C_LI, C_LG: begin
                     alu_o = alu_f(ins[13] ? (ins[12] ? A_SUB : A_MOV)
                        : (ins[12] ? A_OR : A_AND), s.rf[{1'b1, ins[3:0]}],
                        ins[11:4], s.fl);
                     n.rf[{1'b1, ins[3:0]}] = alu_o[7:0];
                     n.fl = alu_o[15:8];
                  end
                  C_ONE: begin
                     alu_o = alu_f({1'b1, ins[12:10]}, s.rf[di], 8'h00,
                        s.fl);
                     n.rf[di] = alu_o[7:0];
                     n.fl = alu_o[15:8];
                  end
                  C_BIT: begin
                     case (ins[12:10])
                        B_TST: n.fl[F_T] = s.rf[di][ins[7:5]];
                        B_TLD: n.rf[di][ins[7:5]] = s.fl[F_T];
                        B_SET: n.fl[ins[7:5]] = 1'b1;
                        B_CLR: n.fl[ins[7:5]] = 1'b0;
                        B_SKS: n.fv = !s.fl[ins[7:5]];
                        B_SKC: n.fv = s.fl[ins[7:5]];
                        default: n.fv = 1'b1;
                     endcase
                  end
                  C_MEM: begin
                     if (ins[12:11] == 2'h3) begin
                        n.ir = ins;
                        n.st = S_WORD2;
                     end else if (ins[8]) begin
                        n.tmp = s.pc;
                        n.pc = {1'b0, zp[15:1]};
                        n.jt = zp;
                        n.ld_src = SRC_PROG;
                        n.ld_dst = di;
                        n.fv = 1'b0;
                        n.st = S_LPM;
                     end else begin
                        aa = pv;
                        if (ins[9]) begin
                           {n.rf[ptr + 5'h01], n.rf[ptr]} = pv + 16'h0001;
                        end
                        ard = !ins[10];
                        awr = ins[10];
                        ad = s.rf[di];
                     end
                  end
                  C_CTL: begin
                     case (ins[12:10])
                        K_PUSH: begin
                           aa = s.sp;
                           awr = 1'b1;
                           ad = s.rf[di];
                           n.sp = s.sp - 16'h0001;
                        end
                        K_POP: begin
                           aa = s.sp + 16'h0001;
                           ard = 1'b1;
                           n.sp = s.sp + 16'h0001;
                        end
                        K_JMP, K_CALL: begin
                           n.ir = ins;
                           n.st = S_WORD2;
                        end
                        K_RET, K_IRQ_EXIT_INSTR: begin
                           dmem_re = 1'b1;
                           dmem_addr = s.sp + 16'h0001;
                           n.irq_exit_instr = (ins[12:10] == K_IRQ_EXIT_INSTR);
                           n.fv = 1'b0;
                           n.st = S_POP1;
                        end
                        K_FWR: begin
                           if (xa >= BOOT_START
                              && (({1'b0, zp[15:1]} < BOOT_START)
                              ? !app_lock : !boot_lock)) begin
                              n.fw_en = 1'b1;
                              n.fw_addr = {1'b0, zp[15:1]};
                              n.fw_data = {s.rf[1], s.rf[0]};
                           end
                        end
                        default: begin
                           prod = mul_f(ins[9:8], s.rf[{1'b1, ins[7:4]}],
                              s.rf[{1'b1, ins[3:0]}]);
                           {n.rf[1], n.rf[0]} = prod[15:0];
                           n.fl[F_C] = prod[16];
                           n.fl[F_Z] = (prod[15:0] == 16'h0000);
                        end
                     endcase
                  end
                  default: begin
                     aa = IO_BASE + {10'h000, ins[11:6]};
                     ard = !ins[12];
                     awr = ins[12];
                     ad = s.rf[di];
                  end
               endcase
            end
         end
         S_WORD2: begin
            n.pc = s.pc + 16'h0001;
            n.st = S_RUN;
            if (s.ir[15:13] == C_CTL) begin
               if (s.ir[12:10] == K_CALL) begin
                  n.tmp = s.pc;
                  n.jt = ins;
                  n.st = S_PUSH1;
               end else begin
                  n.pc = ins;
                  n.fv = 1'b0;
               end
            end else begin
               aa = ins;
               adst = s.ir[4:0];
               ad = s.rf[s.ir[4:0]];
               ard = !s.ir[10];
               awr = s.ir[10];
            end
         end
         S_PUSH1: begin
            dmem_we = 1'b1;
            dmem_addr = s.sp;
            dmem_wdata = s.tmp[7:0];
            n.st = S_PUSH2;
         end
         S_PUSH2: begin
            dmem_we = 1'b1;
            dmem_addr = s.sp - 16'h0001;
            dmem_wdata = s.tmp[15:8];
            n.sp = s.sp - 16'h0002;
            n.pc = s.jt;
            n.fv = 1'b0;
            n.st = S_RUN;
         end
         S_POP1: begin
            n.jt[15:8] = dmem_rdata;
            dmem_re = 1'b1;
            dmem_addr = s.sp + 16'h0002;
            n.st = S_POP2;
         end
         S_POP2: begin
            n.pc = {s.jt[15:8], dmem_rdata};
            n.sp = s.sp + 16'h0002;
            if (s.irq_exit_instr) n.fl[F_I] = 1'b1;
            n.irq_exit_instr = 1'b0;
            n.fv = 1'b0;
            n.st = S_RUN;
         end
         S_LPM: n.st = S_LOAD;
         S_LOAD: begin
            n.rf[s.ld_dst] = (s.ld_src == SRC_PROG)
               ? (s.jt[0] ? prog_data[15:8] : prog_data[7:0])
               : (s.ld_src == SRC_IO) ? io_rdata : dmem_rdata;
            n.pc = s.tmp;
            n.fv = 1'b0;
            n.st = S_RUN;
         end
         default: n.st = S_RUN;
      endcase
      // data space decode: registers, io, then memory
      ioa = 6'(aa - IO_BASE);
      iv = (ioa == IO_SPL) ? s.sp[7:0] : (ioa == IO_SPH) ? s.sp[15:8]
         : s.fl;
      if (awr) begin
         if (aa < IO_BASE) begin
            n.rf[aa[4:0]] = ad;
         end else if (aa < XIO_BASE) begin
            case (ioa)
               IO_SPL: n.sp[7:0] = ad;
               IO_SPH: n.sp[15:8] = ad;
               IO_FLAGS: n.fl = ad;
               default: begin
                  io_we = 1'b1;
                  io_addr = ioa;
                  io_wdata = ad;
               end
            endcase
         end else begin
            dmem_we = 1'b1;
            dmem_addr = aa;
            dmem_wdata = ad;
         end
      end
      if (ard) begin
         if (aa < IO_BASE) begin
            n.rf[adst] = s.rf[aa[4:0]];
         end else if (aa < XIO_BASE && (ioa == IO_SPL || ioa == IO_SPH
            || ioa == IO_FLAGS)) begin
            n.rf[adst] = iv;
         end else begin
            n.tmp = s.pc;
            n.ld_dst = adst;
            n.fv = 1'b0;
            n.st = S_LOAD;
            if (aa < XIO_BASE) begin
               io_re = 1'b1;
               io_addr = ioa;
               n.ld_src = SRC_IO;
            end else begin
               dmem_re = 1'b1;
               dmem_addr = aa;
               n.ld_src = SRC_MEM;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
         s.pc <= RESET_PC;
         s.st <= S_RUN;
      end else begin
         s <= n;
      end
   end

   assign prog_addr = s.pc;
   assign flash_wr_en = s.fw_en;
   assign flash_wr_addr = s.fw_addr;
   assign flash_wr_data = s.fw_data;

   // checks
   logic [IRQ_N-1:0] below_m;
   logic [7:0] rr_sum;
   assign below_m = (IRQ_N'(1) << irq_ack_id) - IRQ_N'(1);
   assign rr_sum = s.rf[ins[9:5]] + s.rf[ins[4:0]];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence push_seq;
      s.st == S_PUSH1 && dmem_we && dmem_addr == s.sp
      ##1 s.st == S_PUSH2 && dmem_we && dmem_addr == $past(s.sp) - 16'h0001;
   endsequence

   reset_start_a: assert property (disable iff (1'b0)
      rst |=> s.pc == RESET_PC && !s.fl[F_I])
      else $error("reset did not clear pc or interrupt enable");
   call_push_a: assert property (
      s.st == S_WORD2 && s.ir[15:13] == C_CTL && s.ir[12:10] == K_CALL
      |=> push_seq ##1 s.pc == s.jt && s.sp == $past(s.sp, 3) - 16'h0002)
      else $error("call did not push two bytes and jump");
   irq_entry_a: assert property (
      irq_ack |-> s.fl[F_I] ##1 !s.fl[F_I] ##0 push_seq)
      else $error("interrupt entry wrong");
   irq_prio_a: assert property (
      irq_ack |-> irq_pend[irq_ack_id] && (irq_pend & below_m) == '0)
      else $error("interrupt priority wrong");
   irq_exit_instr_gie_a: assert property (
      s.st == S_POP2 && s.irq_exit_instr
      |=> s.fl[F_I] && s.sp == $past(s.sp) + 16'h0002)
      else $error("return from interrupt did not restore enable");
   add_one_cycle_a: assert property (
      exec && ins[15:10] == 6'h00 |=> s.st == S_RUN
      && s.rf[$past(ins[9:5])] == $past(rr_sum)
      && s.fl[F_Z] == ($past(rr_sum) == 8'h00))
      else $error("add result or zero flag wrong");
   flash_boot_a: assert property (
      flash_wr_en |-> $past(xa) >= BOOT_START)
      else $error("flash write from outside boot section");
   fetch_each_a: assert property (
      exec && ins[15:13] <= C_ONE
      |=> s.fv && s.pc == $past(s.pc) + 16'h0001)
      else $error("pipeline did not advance");
   sp_push_a: assert property (
      exec && ins[15:10] == {C_CTL, K_PUSH}
      |=> s.sp == $past(s.sp) - 16'h0001)
      else $error("byte push did not decrement stack pointer");
endmodule // rcd_core

// *** core/rcd_pkg.sv ***
// Purpose: shared constants for the 8-bit core datapath
// Assumes: word-addressed program memory, byte-addressed data space
// Notes: instruction field layout is local to this core
package rcd_pkg;
   localparam int NREG = 32;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [15:0] IO_BASE = 16'h0020;
   localparam logic [15:0] XIO_BASE = 16'h0060;
   localparam logic [15:0] VEC_STEP = 16'h0002;
   localparam logic [5:0] IO_SPL = 6'h3D;
   localparam logic [5:0] IO_SPH = 6'h3E;
   localparam logic [5:0] IO_FLAGS = 6'h3F;
   localparam logic [4:0] R_X = 5'h1A;
   localparam logic [4:0] R_Z = 5'h1E;
   localparam int F_C = 0, F_Z = 1, F_N = 2, F_V = 3;
   localparam int F_S = 4, F_H = 5, F_T = 6, F_I = 7;
   // instruction classes, bits 15:13
   localparam logic [2:0] C_RR = 3'h0, C_LI = 3'h1, C_LG = 3'h2;
   localparam logic [2:0] C_ONE = 3'h3, C_BIT = 3'h4, C_MEM = 3'h5;
   localparam logic [2:0] C_CTL = 3'h6, C_IO = 3'h7;
   // alu operations
   localparam logic [3:0] A_ADD = 4'h0, A_ADC = 4'h1, A_SUB = 4'h2;
   localparam logic [3:0] A_SBC = 4'h3, A_AND = 4'h4, A_OR = 4'h5;
   localparam logic [3:0] A_EOR = 4'h6, A_MOV = 4'h7, A_COM = 4'h8;
   localparam logic [3:0] A_NEG = 4'h9, A_INC = 4'hA, A_DEC = 4'hB;
   localparam logic [3:0] A_SHR = 4'hC, A_ROTR = 4'hD, A_SAR = 4'hE;
   localparam logic [3:0] A_NIB = 4'hF;
   // bit operations, bits 12:10 of class C_BIT
   localparam logic [2:0] B_TST = 3'h0, B_TLD = 3'h1, B_SET = 3'h2;
   localparam logic [2:0] B_CLR = 3'h3, B_SKS = 3'h4, B_SKC = 3'h5;
   // control operations, bits 12:10 of class C_CTL
   localparam logic [2:0] K_PUSH = 3'h0, K_POP = 3'h1, K_JMP = 3'h2;
   localparam logic [2:0] K_CALL = 3'h3, K_RET = 3'h4, K_IRQ_EXIT_INSTR = 3'h5;
   localparam logic [2:0] K_FWR = 3'h6, K_MUL = 3'h7;
   localparam logic [1:0] M_FRAC = 2'h3;
   localparam logic [1:0] SRC_MEM = 2'h0, SRC_IO = 2'h1, SRC_PROG = 2'h2;
   typedef enum logic [2:0] {
      S_RUN = 3'b000, S_WORD2 = 3'b001, S_LOAD = 3'b011,
      S_LPM = 3'b010, S_PUSH1 = 3'b110, S_PUSH2 = 3'b111,
      S_POP1 = 3'b101, S_POP2 = 3'b100
   } rcd_state_t;
endpackage

// *** tb/rcd_mem_model.sv ***
// Purpose: program flash, data sram and io space beside the core
// Assumes: every read answers one cycle after its request
// Notes: idle read data shows the inverse of the last value
module rcd_mem_model (
   input logic clk_sys,
   input logic [15:0] prog_addr,
   output logic [15:0] prog_data,
   input logic [15:0] dmem_addr,
   input logic [7:0] dmem_wdata,
   input logic dmem_we,
   input logic dmem_re,
   output logic [7:0] dmem_rdata,
   input logic [5:0] io_addr,
   input logic [7:0] io_wdata,
   input logic io_we,
   input logic io_re,
   output logic [7:0] io_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] prog_mem [0:255];
   logic [7:0] sram [0:2047];
   logic [7:0] io_mem [0:63];
   initial begin
      prog_data = 16'h0000;
      dmem_rdata = 8'h00;
      io_rdata = 8'h00;
   end
   always @(posedge clk_sys) begin
      prog_data <= prog_mem[prog_addr[7:0]];
      if (dmem_we) sram[dmem_addr[10:0]] <= dmem_wdata;
      dmem_rdata <= dmem_re ? sram[dmem_addr[10:0]] : ~dmem_rdata;
      if (io_we) io_mem[io_addr] <= io_wdata;
      io_rdata <= io_re ? io_mem[io_addr] : ~io_rdata;
   end
endmodule // rcd_mem_model

// *** tb/risc_cpu_core_datapath_tb.sv ***
// Purpose: self-checking bench for the core
// Assumes: boot section starts at word 0x80 in this bench
// Notes: bus events are logged and compared per program
module risc_cpu_core_datapath_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rcd_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [15:0] prog_addr, prog_data, dmem_addr, fw_addr, fw_data;
   logic [7:0] dmem_wdata, dmem_rdata, io_wdata, io_rdata;
   logic [5:0] io_addr;
   logic dmem_we, dmem_re, io_we, io_re, irq_ack, fw_en;
   logic [7:0] irq_pend = 8'h00;
   logic [2:0] irq_ack_id;
   logic app_lock = 1'b0;
   logic boot_lock = 1'b0;
   logic [35:0] log_q[$];
   logic [35:0] exp_q[$];
   int errors = 0;
   int n_tests = 0;
   always #5 clk_sys = ~clk_sys;
   rcd_core #(.IRQ_N(8), .BOOT_START(16'h0080)) dut_u (.clk_sys(clk_sys),
      .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
      .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we),
      .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
      .io_rdata(io_rdata), .irq_pend(irq_pend), .irq_ack(irq_ack),
      .irq_ack_id(irq_ack_id), .app_lock(app_lock), .boot_lock(boot_lock),
      .flash_wr_en(fw_en), .flash_wr_addr(fw_addr), .flash_wr_data(fw_data));
   rcd_mem_model mem_u (.clk_sys(clk_sys), .prog_addr(prog_addr),
      .prog_data(prog_data), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
      .dmem_we(dmem_we), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
      .io_rdata(io_rdata));
   function automatic logic [35:0] ev(input logic [3:0] k,
         input logic [15:0] a, input logic [15:0] d);
      return {k, a, d};
   endfunction
   function automatic logic [15:0] imm(input logic [15:0] b, input int d,
         input int k);
      return b | 16'(k << 4) | 16'(d - 16);
   endfunction
   function automatic logic [15:0] iop(input logic [15:0] b, input int a,
         input int d);
      return b | 16'(a << 6) | 16'(d);
   endfunction
   always @(posedge clk_sys) begin
      // registered flash strobe belongs to the older instruction
      if (!rst && fw_en) log_q.push_back(ev(4'h4, fw_addr, fw_data));
      if (!rst && io_we)
         log_q.push_back(ev(4'h1, 16'(io_addr), 16'(io_wdata)));
      if (!rst && dmem_we)
         log_q.push_back(ev(4'h2, dmem_addr, 16'(dmem_wdata)));
      if (!rst && irq_ack) begin
         log_q.push_back(ev(4'h3, 16'h0000, 16'(irq_ack_id)));
         irq_pend[irq_ack_id] <= 1'b0;
      end
   end
   task automatic end_sim();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input int a, input logic [15:0] w[]);
      foreach (w[i]) mem_u.prog_mem[a + i] = w[i];
   endtask
   task automatic start();
      for (int i = 0; i < 256; i++) mem_u.prog_mem[i] = 16'h1C00;
      @(posedge clk_sys);
      #1 rst = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1 check(36'(prog_addr), 36'h0);
      log_q.delete();
      rst = 1'b0;
   endtask
   task automatic wait_mark();
      int n;
      n = 0;
      while (n < 500 && !(log_q.size() > 0 && log_q[$][35:16] === 20'h1003C)) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n == 500) begin
         errors++;
         $display("timeout at %0t", $time);
         end_sim();
      end
   endtask
   task automatic cmp_log();
      check(36'(log_q.size()), 36'(exp_q.size()));
      foreach (exp_q[i]) if (i < log_q.size()) check(log_q[i], exp_q[i]);
   endtask
   task automatic t_alu();
      logic [15:0] p;
      start();
      put(0, '{imm(16'h2000, 16, 'h9A), imm(16'h2000, 17, 'h88), 16'h0211,
         iop(16'hF000, 'h10, 16), iop(16'hE000, 'h3F, 19),
         iop(16'hF000, 'h13, 19), imm(16'h4000, 16, 'h0F),
         iop(16'hF000, 'h11, 16), 16'h6010, iop(16'hF000, 'h12, 16),
         imm(16'h2000, 18, 'h77), iop(16'hF000, 'h3D, 18),
         iop(16'hF000, 'h3C, 17), 16'hC800, 16'h000D});
      repeat (2) @(posedge clk_sys);
      #1 p = prog_addr;
      repeat (3) begin
         @(posedge clk_sys);
         #1 check(36'(prog_addr), 36'(p + 16'h0001));
         p = prog_addr;
      end
      wait_mark();
      exp_q = '{ev(1, 'h10, 'h22), ev(1, 'h13, 'h39), ev(1, 'h11, 'h02),
         ev(1, 'h12, 'hFD), ev(1, 'h3C, 'h88)};
      cmp_log();
   endtask
   task automatic t_call();
      start();
      put(0, '{imm(16'h2000, 16, 'hFF), iop(16'hF000, 'h3D, 16),
         imm(16'h2000, 17, 'h04), iop(16'hF000, 'h3E, 17), 16'hCC00,
         16'h0040, iop(16'hE000, 'h3D, 18), iop(16'hF000, 'h22, 18),
         iop(16'hF000, 'h21, 16), iop(16'hF000, 'h3C, 17), 16'hC800,
         16'h000A});
      put('h40, '{iop(16'hF000, 'h20, 17), 16'hD000});
      wait_mark();
      exp_q = '{ev(2, 'h04FF, 'h06), ev(2, 'h04FE, 'h00), ev(1, 'h20, 'h04),
         ev(1, 'h22, 'hFF), ev(1, 'h21, 'hFF), ev(1, 'h3C, 'h04)};
      cmp_log();
   endtask
   task automatic t_irq();
      irq_pend = 8'h24;
      start();
      put(0, '{16'hC800, 16'h0020});
      put(6, '{iop(16'hF000, 'h30, 16), 16'hD400});
      put(12, '{iop(16'hF000, 'h31, 17), iop(16'hF000, 'h3C, 17), 16'hD400});
      put('h20, '{imm(16'h2000, 16, 'hFF), iop(16'hF000, 'h3D, 16),
         imm(16'h2000, 17, 'h04), iop(16'hF000, 'h3E, 17),
         iop(16'hF000, 'h32, 17), 16'h88E0, 16'hC800, 16'h0026});
      wait_mark();
      foreach (log_q[i]) if (log_q[i][35:32] == 4'h2) log_q[i][15:0] = 16'h0;
      exp_q = '{ev(1, 'h32, 'h04), ev(3, 0, 2), ev(2, 'h04FF, 0),
         ev(2, 'h04FE, 0), ev(1, 'h30, 'hFF), ev(3, 0, 5), ev(2, 'h04FF, 0),
         ev(2, 'h04FE, 0), ev(1, 'h31, 'h04), ev(1, 'h3C, 'h04)};
      cmp_log();
   endtask
   task automatic t_flash(input logic lock);
      app_lock = lock;
      boot_lock = !lock;
      start();
      put(0, '{imm(16'h2000, 16, 'h34), imm(16'h2000, 17, 'h12), 16'h1C10,
         16'h1C31, imm(16'h2000, 30, 'h20), imm(16'h2000, 31, 'h00),
         16'hD800, 16'hC800, 16'h0080});
      put('h80, '{16'hD800, imm(16'h2000, 31, 'h01), 16'hD800,
         iop(16'hF000, 'h3C, 17), 16'hC800, 16'h0084});
      wait_mark();
      exp_q = '{ev(1, 'h3C, 'h12)};
      if (lock) exp_q.push_front(ev(4, 'h0090, 'h1234));
      else exp_q.push_front(ev(4, 'h0010, 'h1234));
      cmp_log();
   endtask
   task automatic t_mem();
      start();
      put(0, '{imm(16'h2000, 26, 'h70), imm(16'h2000, 27, 'h00),
         imm(16'h2000, 16, 'hA5), 16'hA610, imm(16'h2000, 26, 'h05),
         16'hA410, iop(16'hF000, 'h23, 5), 16'hB811, 16'h0070,
         iop(16'hF000, 'h24, 17), imm(16'h2000, 30, 'hE1),
         imm(16'h2000, 31, 'h01), 16'hB112, iop(16'hF000, 'h25, 18),
         imm(16'h2000, 20, 'hFE), imm(16'h2000, 21, 'h03), 16'hDD45,
         iop(16'hF000, 'h26, 0), iop(16'hF000, 'h27, 1), 16'hDC45,
         iop(16'hF000, 'h28, 1), 16'h6414, 16'h9000,
         iop(16'hF000, 'h2B, 20), iop(16'hF000, 'h2C, 20),
         imm(16'h2000, 22, 'hFF), iop(16'hF000, 'h3D, 22),
         imm(16'h2000, 23, 'h04), iop(16'hF000, 'h3E, 23), 16'hC010,
         16'hC418, iop(16'hF000, 'h29, 24), iop(16'hF000, 'h3C, 16),
         16'hC800, 16'h0021});
      put('hF0, '{16'h5AC3});
      wait_mark();
      exp_q = '{ev(2, 'h70, 'hA5), ev(1, 'h23, 'hA5), ev(1, 'h24, 'hA5),
         ev(1, 'h25, 'h5A), ev(1, 'h26, 'hFA), ev(1, 'h27, 'hFF),
         ev(1, 'h28, 'h02), ev(1, 'h2C, 'h02), ev(2, 'h04FF, 'hA5),
         ev(1, 'h29, 'hA5), ev(1, 'h3C, 'hA5)};
      cmp_log();
   endtask
   initial begin
      t_alu();
      t_call();
      t_irq();
      t_flash(1'b1);
      t_flash(1'b0);
      t_mem();
      end_sim();
   end
endmodule // risc_cpu_core_datapath_tb
